// >>> paw_dev.sv
`timescale 1ns/1ps
module paw_dev #(
  parameter int ADDR_W = paw_pkg::ADDR_W,
  parameter int DATA_W = paw_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  paw_if.dev bus,
  output logic wr_strobe_ff,
  output logic [ADDR_W-1:0] wr_addr_ff,
  output logic [DATA_W-1:0] wr_data_ff,
  output logic [1:0] wr_lanes_ff,
  output logic write_active_ff
);
  // ---------------------------------------------------------------
  // write pulse tracking
  // ---------------------------------------------------------------
  logic overlap;
  logic [1:0] lanes_now;
  logic nxt_wr_strobe;
  logic [ADDR_W-1:0] nxt_wr_addr;
  logic [DATA_W-1:0] nxt_wr_data;
  logic [1:0] nxt_wr_lanes;
  logic nxt_write_active;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic [1:0] lanes_ff, nxt_lanes;

  assign overlap = !bus.chip_select_n && !bus.write_enable_n;
  assign lanes_now = {!bus.upper_lane_enable_n, !bus.lower_lane_enable_n};

  always_comb begin
    nxt_write_active = overlap && (lanes_now != 2'h0);
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_lanes = lanes_ff;
    if (nxt_write_active) begin
      nxt_addr = bus.addr;
      nxt_data = bus.data_to_dev;
      nxt_lanes = lanes_now;
    end
    // commit on the first of select or enable rising
    nxt_wr_strobe = write_active_ff && !overlap;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_lanes = wr_lanes_ff;
    if (nxt_wr_strobe) begin
      nxt_wr_addr = addr_ff;
      nxt_wr_data = data_ff;
      nxt_wr_lanes = lanes_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      write_active_ff <= 1'b0;
      wr_strobe_ff <= 1'b0;
      addr_ff <= '0;
      data_ff <= '0;
      lanes_ff <= 2'h0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      wr_lanes_ff <= 2'h0;
    end else begin
      write_active_ff <= nxt_write_active;
      wr_strobe_ff <= nxt_wr_strobe;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      lanes_ff <= nxt_lanes;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      wr_lanes_ff <= nxt_wr_lanes;
    end
  end

  // ---------------------------------------------------------------
  // pins the write path never drives
  // ---------------------------------------------------------------
  // clock, address strobe and mode pin do not steer a write
  assign bus.wait_n = 1'b1;
  assign bus.wait_oe = 1'b0;
  assign bus.data_from_dev = '0;
  assign bus.data_from_dev_oe = 1'b0;
endmodule : paw_dev

// >>> paw_host.sv
`timescale 1ns/1ps
module paw_host #(
  parameter int ADDR_W = paw_pkg::ADDR_W,
  parameter int DATA_W = paw_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  paw_if.host bus,
  input wire logic req_valid,
  input wire logic req_burst,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [1:0] req_lanes,
  output logic req_ready_ff,
  output logic done_ff
);
  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PAW_IDLE = 2'h0,
    PAW_SETUP = 2'h1,
    PAW_PULSE = 2'h3,
    PAW_GAP = 2'h2
  } paw_state_type;

  localparam int PULSE_CYC = (paw_pkg::SEL_CYC > paw_pkg::WP_CYC) ? paw_pkg::SEL_CYC :
                             paw_pkg::WP_CYC;
  localparam int PULSE_MIN = (PULSE_CYC > paw_pkg::ADDR_CYC) ? PULSE_CYC : paw_pkg::ADDR_CYC;
  localparam int PULSE_BASE = (PULSE_MIN > paw_pkg::LANE_CYC) ? PULSE_MIN : paw_pkg::LANE_CYC;
  localparam int PULSE_DATA = (PULSE_BASE > paw_pkg::DATA_CYC) ? PULSE_BASE : paw_pkg::DATA_CYC;
  localparam int PULSE_LONG = (PULSE_DATA > paw_pkg::LONG_WP_CYC) ? PULSE_DATA :
                              paw_pkg::LONG_WP_CYC;
  localparam logic [7:0] PULSE_N = 8'(PULSE_DATA);
  localparam logic [7:0] PULSE_LONG_N = 8'(PULSE_LONG);
  localparam logic [7:0] GAP_N = 8'(paw_pkg::GAP_CYC);
  localparam logic [7:0] REC_N = 8'(paw_pkg::REC_CYC);
  localparam logic [7:0] RUN_N = 8'(paw_pkg::LONG_RUN_WRITES);

  paw_state_type state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] run_ff, nxt_run;
  logic cs_n_ff, nxt_cs_n;
  logic we_n_ff, nxt_we_n;
  logic ub_n_ff, nxt_ub_n;
  logic lb_n_ff, nxt_lb_n;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] data_ff, nxt_data;
  logic doe_ff, nxt_doe;
  logic nxt_ready;
  logic nxt_done;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_cs_n = cs_n_ff;
    nxt_we_n = we_n_ff;
    nxt_ub_n = ub_n_ff;
    nxt_lb_n = lb_n_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_doe = doe_ff;
    nxt_ready = 1'b0;
    nxt_done = 1'b0;
    unique case (state_ff)
      PAW_IDLE: begin
        nxt_ready = 1'b1;
        if (req_valid && req_ready_ff && (req_lanes != 2'h0)) begin
          // address and data placed a cycle ahead of the pulse
          nxt_addr = req_addr;
          nxt_data = req_data;
          nxt_doe = 1'b1;
          nxt_ub_n = !req_lanes[1];
          nxt_lb_n = !req_lanes[0];
          nxt_cs_n = 1'b0;
          nxt_ready = 1'b0;
          nxt_state = PAW_SETUP;
        end
      end
      PAW_SETUP: begin
        nxt_we_n = 1'b0;
        nxt_run = (run_ff == paw_pkg::CNT_MAX) ? run_ff : run_ff + paw_pkg::CNT_ONE;
        // long runs load PULSE_LONG_N, two cycles at the 40 ns clock, the same as PULSE_N
        nxt_cnt = (run_ff >= RUN_N) ? PULSE_LONG_N : PULSE_N;
        nxt_state = PAW_PULSE;
      end
      PAW_PULSE: begin
        nxt_cnt = cnt_ff - paw_pkg::CNT_ONE;
        if (cnt_ff == paw_pkg::CNT_ONE) begin
          // enable rises first; select, address, data held
          nxt_we_n = 1'b1;
          nxt_cnt = req_burst ? GAP_N : REC_N;
          nxt_done = 1'b1;
          nxt_state = PAW_GAP;
        end
      end
      PAW_GAP: begin
        nxt_cnt = cnt_ff - paw_pkg::CNT_ONE;
        if (cnt_ff <= paw_pkg::CNT_ONE) begin
          if (req_burst && req_valid && (req_lanes != 2'h0)) begin
            // next write of a multiple-write run, select kept low
            nxt_addr = req_addr;
            nxt_data = req_data;
            nxt_ub_n = !req_lanes[1];
            nxt_lb_n = !req_lanes[0];
            nxt_state = PAW_SETUP;
          end else begin
            nxt_cs_n = 1'b1;
            nxt_ub_n = 1'b1;
            nxt_lb_n = 1'b1;
            nxt_doe = 1'b0;
            nxt_run = paw_pkg::CNT_ZERO;
            nxt_state = PAW_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= PAW_IDLE;
      cnt_ff <= paw_pkg::CNT_ZERO;
      run_ff <= paw_pkg::CNT_ZERO;
      cs_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      ub_n_ff <= 1'b1;
      lb_n_ff <= 1'b1;
      addr_ff <= '0;
      data_ff <= '0;
      doe_ff <= 1'b0;
      req_ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      cs_n_ff <= nxt_cs_n;
      we_n_ff <= nxt_we_n;
      ub_n_ff <= nxt_ub_n;
      lb_n_ff <= nxt_lb_n;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      doe_ff <= nxt_doe;
      req_ready_ff <= nxt_ready;
      done_ff <= nxt_done;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  assign bus.chip_select_n = cs_n_ff;
  assign bus.write_enable_n = we_n_ff;
  assign bus.upper_lane_enable_n = ub_n_ff;
  assign bus.lower_lane_enable_n = lb_n_ff;
  assign bus.addr = addr_ff;
  assign bus.data_to_dev = data_ff;
  assign bus.data_to_dev_oe = doe_ff;
  assign bus.output_enable_n = 1'b1;
  assign bus.mode_set_pin_n = 1'b1;
  assign bus.address_valid_strobe_n = 1'b0;
  // host runs at 25 MHz, under the 66 MHz ceiling
endmodule : paw_host

// >>> paw_if.sv
`timescale 1ns/1ps
interface paw_if #(
  parameter int ADDR_W = paw_pkg::ADDR_W,
  parameter int DATA_W = paw_pkg::DATA_W
);
  logic chip_select_n;
  logic write_enable_n;
  logic output_enable_n;
  logic upper_lane_enable_n;
  logic lower_lane_enable_n;
  logic address_valid_strobe_n;
  logic mode_set_pin_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_to_dev;
  logic data_to_dev_oe;
  logic [DATA_W-1:0] data_from_dev;
  logic data_from_dev_oe;
  logic wait_n;
  logic wait_oe;
  modport dev (
    input chip_select_n, write_enable_n, output_enable_n, upper_lane_enable_n,
    input lower_lane_enable_n, address_valid_strobe_n, mode_set_pin_n, addr,
    input data_to_dev, data_to_dev_oe,
    output data_from_dev, data_from_dev_oe, wait_n, wait_oe
  );
  modport host (
    output chip_select_n, write_enable_n, output_enable_n, upper_lane_enable_n,
    output lower_lane_enable_n, address_valid_strobe_n, mode_set_pin_n, addr,
    output data_to_dev, data_to_dev_oe,
    input data_from_dev, data_from_dev_oe, wait_n, wait_oe
  );
endinterface : paw_if

// >>> paw_monitor.sv
`timescale 1ns/1ps
module paw_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic mode_set_pin_n,
  input wire logic [paw_pkg::ADDR_W-1:0] addr,
  input wire logic [paw_pkg::DATA_W-1:0] data_to_dev,
  input wire logic data_to_dev_oe,
  input wire logic data_from_dev_oe,
  input wire logic wait_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic overlap;
  assign overlap = !chip_select_n && !write_enable_n;
  chk_far_undriven: assert property (!wait_oe && !data_from_dev_oe)
    else $error("device drove wait or data");
  chk_oe_quiet: assert property (!write_enable_n |-> output_enable_n && data_to_dev_oe)
    else $error("output enable low or data released in write");
  chk_mode_high: assert property (mode_set_pin_n)
    else $error("mode pin low");
  chk_pulse_len: assert property ($rose(write_enable_n) |-> $past(overlap, 2))
    else $error("write pulse too short");
  chk_select_lead: assert property ($rose(write_enable_n) |-> !$past(chip_select_n, 3))
    else $error("select low too late");
  chk_addr_hold: assert property ((!write_enable_n || $rose(write_enable_n)) |->
    $stable(addr) && $stable(data_to_dev)) else $error("address or data moved in write");
  chk_lane_held: assert property (!write_enable_n |->
    !(upper_lane_enable_n && lower_lane_enable_n) && $stable(upper_lane_enable_n)
    && $stable(lower_lane_enable_n)) else $error("lanes off or moved in write");
  chk_gap_bound: assert property ($rose(write_enable_n) |=> write_enable_n ##[0:2]
    (chip_select_n || !write_enable_n)) else $error("write gap out of range");
  cover property (overlap && !upper_lane_enable_n && lower_lane_enable_n);
  cover property (overlap && upper_lane_enable_n && !lower_lane_enable_n);
  cover property ($rose(write_enable_n) ##[1:3] (!chip_select_n && $fell(write_enable_n)));
endmodule : paw_monitor

// >>> paw_pkg.sv
package paw_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 40;
  // minimum select, address and lane hold to end of write
  localparam int SELECT_TO_WRITE_END_NS = 60;
  localparam int ADDRESS_TO_WRITE_END_NS = 60;
  localparam int LANE_TO_WRITE_END_NS = 60;
  localparam int WRITE_PULSE_WIDTH_NS = 55;
  localparam int LONG_WRITE_PULSE_WIDTH_NS = 70;
  localparam int LONG_RUN_WRITES = 50;
  localparam int WRITE_HIGH_GAP_NS = 5;
  localparam int WRITE_RECOVERY_NS = 0;
  localparam int DATA_TO_WRITE_END_NS = 30;
  localparam int READ_LATENCY = 5;
  localparam int MODE_PIN_LOW_MAX_NS = 500;
  // least times round up to cycles
  localparam int SEL_CYC = (SELECT_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_CYC = (ADDRESS_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LANE_CYC = (LANE_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_WP_CYC = (LONG_WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_RAW = (WRITE_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_RAW < 1) ? 1 : GAP_RAW;
  localparam int REC_RAW = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CYC = (REC_RAW < 1) ? 1 : REC_RAW;
  localparam int DATA_CYC = (DATA_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // gaps must stay under latency-1 clocks
  localparam int GAP_MAX_CYC = READ_LATENCY - 2;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
endpackage : paw_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_burst = 1'b0, req_ready, done;
  logic [paw_pkg::ADDR_W-1:0] req_addr = 23'h000000, d_addr, b_addr;
  logic [paw_pkg::DATA_W-1:0] req_data = 16'h0000, d_data, b_data;
  logic [1:0] req_lanes = 2'h0, d_lanes, b_lanes, seen_lanes;
  logic d_strobe, d_active, b_strobe, b_active;
  logic [40:0] rows [4] = '{{2'h1, 23'h000001, 16'h00A5}, {2'h2, 23'h000002, 16'h5A00},
    {2'h3, 23'h7FFFFF, 16'hFFFF}, {2'h3, 23'h000000, 16'h0000}};
  int miscompares = 0, total_checks = 0, strobes = 0, dones = 0, bstrobes = 0, cs_rises = 0;
  paw_if bus();
  paw_if bad_bus();
  paw_host paw_host_i (.clk(clk), .rst(rst), .bus(bus), .req_valid(req_valid),
    .req_burst(req_burst), .req_addr(req_addr), .req_data(req_data), .req_lanes(req_lanes),
    .req_ready_ff(req_ready), .done_ff(done));
  paw_dev paw_dev_i (.clk(clk), .rst(rst), .bus(bus), .wr_strobe_ff(d_strobe),
    .wr_addr_ff(d_addr), .wr_data_ff(d_data), .wr_lanes_ff(d_lanes), .write_active_ff(d_active));
  paw_dev paw_dev_bad_i (.clk(clk), .rst(rst), .bus(bad_bus), .wr_strobe_ff(b_strobe),
    .wr_addr_ff(b_addr), .wr_data_ff(b_data), .wr_lanes_ff(b_lanes), .write_active_ff(b_active));
  paw_monitor paw_monitor_i (.clk(clk), .rst(rst), .chip_select_n(bus.chip_select_n),
    .write_enable_n(bus.write_enable_n), .output_enable_n(bus.output_enable_n),
    .upper_lane_enable_n(bus.upper_lane_enable_n), .lower_lane_enable_n(bus.lower_lane_enable_n),
    .mode_set_pin_n(bus.mode_set_pin_n), .addr(bus.addr), .data_to_dev(bus.data_to_dev),
    .data_to_dev_oe(bus.data_to_dev_oe), .data_from_dev_oe(bus.data_from_dev_oe),
    .wait_oe(bus.wait_oe));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (d_strobe === 1'b1) strobes++;
    if (b_strobe === 1'b1) bstrobes++;
    if (done === 1'b1) dones++;
    if (bus.chip_select_n === 1'b0 && bus.write_enable_n === 1'b0)
      seen_lanes <= ~{bus.upper_lane_enable_n, bus.lower_lane_enable_n};
  end
  always @(posedge bus.chip_select_n) cs_rises++;
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task tick(input logic ok);
    @(negedge clk);
    if (!ok) begin
      miscompares++;
      report_and_stop();
    end
  endtask : tick
  // one host write; returns while done stands, or on the last write once the device strobe is seen, so a burst places its next word in time
  task send(input logic [40:0] r, input logic burst, input logic last);
    int k;
    for (k = 0; !burst && req_ready !== 1'b1; k++) tick(k < 50);
    {req_lanes, req_addr, req_data} = r;
    req_burst = burst;
    req_valid = 1'b1;
    k = 0;
    do begin
      tick(k < 50);
      k++;
    end while (done !== 1'b1);
    if (last) {req_valid, req_burst} = 2'h0;
    for (k = 0; last && d_strobe !== 1'b1; k++) tick(k < 50);
  endtask : send
  task bad_write(input logic [1:0] lanes_n, input logic end_cs, input logic [22:0] a);
    {bad_bus.chip_select_n, bad_bus.write_enable_n} = 2'h0;
    {bad_bus.upper_lane_enable_n, bad_bus.lower_lane_enable_n} = lanes_n;
    bad_bus.addr = a;
    bad_bus.data_to_dev = a[15:0];
    repeat (3) begin
      @(negedge clk);
      bad_bus.address_valid_strobe_n = ~bad_bus.address_valid_strobe_n;
    end
    cmp("write active", lanes_n != 2'h3, b_active);
    if (end_cs) bad_bus.chip_select_n = 1'b1;
    else bad_bus.write_enable_n = 1'b1;
    repeat (3) @(negedge clk);
    {bad_bus.chip_select_n, bad_bus.write_enable_n} = 2'h3;
    {bad_bus.upper_lane_enable_n, bad_bus.lower_lane_enable_n} = 2'h3;
    bad_bus.data_to_dev = ~a[15:0];
    @(negedge clk);
  endtask : bad_write
  initial begin
    {bad_bus.chip_select_n, bad_bus.write_enable_n, bad_bus.output_enable_n} = 3'h7;
    {bad_bus.upper_lane_enable_n, bad_bus.lower_lane_enable_n} = 2'h3;
    {bad_bus.address_valid_strobe_n, bad_bus.mode_set_pin_n} = 2'h3;
    {bad_bus.addr, bad_bus.data_to_dev, bad_bus.data_to_dev_oe} = 40'h0;
    repeat (10) @(negedge clk);
    cmp("cs_n in reset", 1'b1, bus.chip_select_n);
    cmp("ready in reset", 1'b0, req_ready);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      send(rows[i], 1'b0, 1'b1);
      cmp("addr", rows[i][38:16], d_addr);
      cmp("data", rows[i][15:0], d_data);
      cmp("lanes", rows[i][40:39], d_lanes);
      cmp("wire lanes", rows[i][40:39], seen_lanes);
    end
    $display("table done");
    {req_lanes, req_valid} = 3'h1;
    repeat (10) @(negedge clk);
    cmp("lanes zero refused", 32'd4, strobes);
    cmp("active refused", 32'd0, d_active);
    req_valid = 1'b0;
    $display("refusal done");
    @(negedge clk);
    cs_rises = 0;
    for (int i = 0; i < 51; i++) send({2'h3, 23'h000100 + 23'(i), 16'(i)}, 1'b1, i == 50);
    repeat (4) @(negedge clk);
    cmp("long run strobes", 32'd55, strobes);
    cmp("last burst addr", 23'h000132, d_addr);
    cmp("select rises", 32'd1, cs_rises);
    cmp("done count", strobes, dones);
    $display("burst done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    cmp("strobe in reset", 1'b0, d_strobe);
    rst = 1'b0;
    send(rows[0], 1'b0, 1'b1);
    cmp("addr after reset", rows[0][38:16], d_addr);
    $display("second reset done");
    bad_write(2'h3, 1'b0, 23'h000011);
    cmp("no lane no write", 32'd0, bstrobes);
    bad_write(2'h2, 1'b1, 23'h000022);
    cmp("select end", 32'd1, bstrobes);
    cmp("select end addr", 23'h000022, b_addr);
    cmp("select end lanes", 2'h1, b_lanes);
    bad_write(2'h1, 1'b0, 23'h000033);
    cmp("enable end", 32'd2, bstrobes);
    cmp("enable end data", 16'h0033, b_data);
    $display("fault end done");
    report_and_stop();
  end
endmodule : tb
